// File: pkg/imp_fifo_pkg.sv
`default_nettype none
package imp_fifo_pkg;

    // Queue geometry.
    localparam int ENTRY_W = 24;
    localparam int TAG_W = 4;
    localparam int DATA_W = 20;
    localparam int DEPTH = 256;
    localparam int PTR_W = 8;
    localparam int CNT_W = 9;

    // Entry encodings.
    localparam logic [TAG_W-1:0] TAG_INPHASE = 4'h1;
    localparam logic [TAG_W-1:0] TAG_QUAD = 4'h2;
    localparam logic [ENTRY_W-1:0] MARKER_WORD = 24'hFFFFFE;
    localparam logic [ENTRY_W-1:0] INVALID_WORD = 24'hFFFFFF;
    localparam logic [ENTRY_W-1:0] SPURIOUS_WORD = 24'h004000;

    // Timing subsystem widths.
    localparam int DIV_W = 13;
    localparam int OSR_W = 11;
    localparam int PROD_W = 24;
    localparam int DAC_W = 10;
    localparam int SETTLE_W = 19;

    // Data must start flowing this long after a channel is enabled.
    localparam int START_TIME_NS = 2000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int START_CYCLES = START_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_SINE_CURRENT = 2'b00,
        MODE_SINE_VOLTAGE = 2'b01,
        MODE_SQUARE_BRIDGE = 2'b10,
        MODE_TX_STANDBY = 2'b11
    } stim_mode_t;

    typedef enum logic [1:0] {
        CH_OFF = 2'b00,
        CH_SETTLE = 2'b01,
        CH_RUN = 2'b10,
        CH_SLEEP = 2'b11
    } ch_state_t;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [DATA_W-1:0] data;
    } entry_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] result;
    } conv_t;

    typedef struct packed {
        logic stim_on;
        logic dds_run;
        logic return_switch;
        logic amp_low_power;
        logic bridge_on;
        logic sine_current;
        logic sine_voltage;
        logic bias_hold;
        logic receive_on;
    } drive_ctl_t;

endpackage : imp_fifo_pkg
`default_nettype wire

// File: hdl/sample_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sample_mem (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [imp_fifo_pkg::PTR_W-1:0] waddr_i,
    input wire logic [imp_fifo_pkg::ENTRY_W-1:0] wdata_i,
    // Read port
    input wire logic re_i,
    input wire logic [imp_fifo_pkg::PTR_W-1:0] raddr_i,
    output logic [imp_fifo_pkg::ENTRY_W-1:0] rdata_o
);
    import imp_fifo_pkg::*;

    logic [ENTRY_W-1:0] mem_q [DEPTH];
    logic [ENTRY_W-1:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (re_i) begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule : sample_mem
`default_nettype wire

// File: hdl/sample_fifo_ctrl.sv
// Operation
// R1: Queue holds up to 256 24-bit entries.
// R2: Top four bits carry the source tag.
// R3: Converter entries: 4-bit tag, 20-bit result.
// R4: In-phase entry uses tag 0001.
// R5: Quadrature entry uses tag 0010.
// R6: Marker entry is all ones, bit0 zero.
// R7: Marker request inserts one marker, self-clears.
// R8: Empty read returns all-ones invalid word.
// R9: Disable during push adds 0x004000 entry.
// R10: Host disables after event or discards.
// R11: Host powers reference before measuring.
// R12: Host waits before enabling phase channels.
// R13: Data starts within 2 ms of enable.
// R14: Host clears all enables for shutdown.
// R15: Drive mode 3 puts transmit in standby.
// R16: Standby stops stimulus, keeps electrode bias.
// R17: Standby sleeps receiver unless awake bit.
// R18: Standby: synthesizer runs, return switch, amps low.
// R19: Standby switches the square-wave bridge off.
// R20: Three stimulus types chosen by drive mode.
// R21: Mode 0 selects sine current stimulus.
// R22: Synthesizer feeds 10-bit current converter.
// R23: Stimulus frequency programmable, 16 Hz to 806 kHz.
// R24: Mode 1 selects sine voltage stimulus.
// R25: Stimulus rate is clock over divider times oversampling.
// R26: Sample rate is clock over divider times oversampling.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_ctrl #(
    parameter int unsigned START_CYCLES = imp_fifo_pkg::START_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control bits
    input wire logic reference_power_on_i,
    input wire logic inphase_channel_on_i,
    input wire logic quadrature_channel_on_i,
    input wire imp_fifo_pkg::stim_mode_t stimulus_type_select_i,
    input wire logic receive_awake_in_standby_i,
    input wire logic marker_request_i,
    // Timing configuration
    input wire logic [imp_fifo_pkg::DIV_W-1:0] stimulus_divider_i,
    input wire logic [imp_fifo_pkg::OSR_W-1:0] stimulus_oversampling_i,
    input wire logic [imp_fifo_pkg::DIV_W-1:0] converter_divider_i,
    input wire logic [imp_fifo_pkg::OSR_W-1:0] converter_oversampling_i,
    // Converter results
    input wire imp_fifo_pkg::conv_t inphase_result_i,
    input wire imp_fifo_pkg::conv_t quadrature_result_i,
    // Host read side
    input wire logic rd_req_i,
    output logic rd_ready_o,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output imp_fifo_pkg::entry_t out_data_o,
    output logic [imp_fifo_pkg::CNT_W-1:0] fifo_count_o,
    output logic fifo_full_o,
    // Analog front-end control
    output imp_fifo_pkg::drive_ctl_t drive_ctl_o,
    output logic [imp_fifo_pkg::DAC_W-1:0] dac_code_o,
    output logic conv_start_o,
    output logic stim_period_o
);
    import imp_fifo_pkg::*;

    function automatic logic [PROD_W-1:0] last_count(
        input logic [DIV_W-1:0] div,
        input logic [OSR_W-1:0] osr
    );
        logic [PROD_W-1:0] prod;
        prod = PROD_W'(div) * PROD_W'(osr);
        return (prod == '0) ? '0 : prod - PROD_W'(1);
    endfunction : last_count

    // Channel sequencing.
    ch_state_t state_q, state_d;
    logic [SETTLE_W-1:0] settle_q;
    logic chan_on_q;
    wire logic chan_on;
    wire logic chan_fall;
    wire logic standby;
    wire logic rx_active;
    wire logic settle_done;
    wire logic first_start;

    // A channel only runs behind a powered reference. [R11] [R12] [R14]
    assign chan_on = reference_power_on_i
        & (inphase_channel_on_i | quadrature_channel_on_i);
    assign chan_fall = chan_on_q & ~chan_on;
    assign standby = (stimulus_type_select_i == MODE_TX_STANDBY); // [R15]
    assign rx_active = (state_q == CH_SETTLE) | (state_q == CH_RUN)
        | ((state_q == CH_SLEEP) & receive_awake_in_standby_i); // [R17]

    // Timing subsystem: divider and oversampling counters.
    logic [PROD_W-1:0] conv_cnt_q;
    logic [PROD_W-1:0] stimulus_divider_cnt_q;
    logic [OSR_W-1:0] phase_q;
    wire logic conv_tick;
    wire logic stimulus_divider_tick;
    wire logic phase_wrap;

    assign conv_tick = (conv_cnt_q == '0); // [R26]
    assign stimulus_divider_tick = (stimulus_divider_cnt_q == '0); // [R23]
    assign phase_wrap = (phase_q >= stimulus_oversampling_i - OSR_W'(1));
    assign settle_done = (settle_q == SETTLE_W'(START_CYCLES - 1));
    // The first conversion is forced at the deadline in case the
    // programmed sample period is longer than the start-up limit.
    assign first_start = (state_q == CH_SETTLE) & (conv_tick | settle_done);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CH_OFF: begin
                if (chan_on) begin
                    state_d = CH_SETTLE;
                end
            end
            CH_SETTLE: begin
                if (!chan_on) begin
                    state_d = CH_OFF;
                end else if (first_start) begin
                    state_d = standby ? CH_SLEEP : CH_RUN; // [R13]
                end
            end
            CH_RUN: begin
                if (!chan_on) begin
                    state_d = CH_OFF;
                end else if (standby) begin
                    state_d = CH_SLEEP;
                end
            end
            CH_SLEEP: begin
                if (!chan_on) begin
                    state_d = CH_OFF;
                end else if (!standby) begin
                    state_d = CH_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= CH_OFF;
            chan_on_q <= 1'b0;
            settle_q <= '0;
        end else begin
            state_q <= state_d;
            chan_on_q <= chan_on;
            settle_q <= (state_q == CH_SETTLE) ? settle_q + SETTLE_W'(1) : '0;
        end
    end

    // Converter counter reloads while the channel is off so a new run starts a full period; stimulus counters reload with reference off. [R25] [R26]
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            conv_cnt_q <= '0;
            stimulus_divider_cnt_q <= '0;
            phase_q <= '0;
        end else begin
            conv_cnt_q <= (conv_tick || state_q == CH_OFF)
                ? last_count(converter_divider_i, converter_oversampling_i)
                : conv_cnt_q - PROD_W'(1);
            stimulus_divider_cnt_q <= (stimulus_divider_tick || !reference_power_on_i)
                ? last_count(stimulus_divider_i, OSR_W'(1))
                : stimulus_divider_cnt_q - PROD_W'(1);
            if (!reference_power_on_i) begin
                phase_q <= '0;
            end else if (stimulus_divider_tick) begin
                phase_q <= phase_wrap ? '0 : phase_q + OSR_W'(1); // [R22]
            end
        end
    end

    // Drive control decode.
    drive_ctl_t drive_d;
    drive_ctl_t drive_q;
    wire logic stim_run;

    assign stim_run = reference_power_on_i & chan_on & ~standby; // [R16]
    assign drive_d.stim_on = stim_run;
    assign drive_d.dds_run = reference_power_on_i; // [R18]
    assign drive_d.return_switch = reference_power_on_i & standby; // [R18]
    assign drive_d.amp_low_power = ~reference_power_on_i | standby; // [R18]
    assign drive_d.bridge_on = stim_run
        & (stimulus_type_select_i == MODE_SQUARE_BRIDGE); // [R19] [R20]
    assign drive_d.sine_current = stim_run
        & (stimulus_type_select_i == MODE_SINE_CURRENT); // [R21]
    assign drive_d.sine_voltage = stim_run
        & (stimulus_type_select_i == MODE_SINE_VOLTAGE); // [R24]
    assign drive_d.bias_hold = chan_on; // [R16]
    assign drive_d.receive_on = rx_active; // [R17]

    // The converter code is the raw phase index; shaping it into a sine
    // is left to the converter's lookup.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            drive_q <= '0;
            dac_code_o <= '0;
            conv_start_o <= 1'b0;
            stim_period_o <= 1'b0;
        end else begin
            drive_q <= drive_d;
            dac_code_o <= phase_q[DAC_W-1:0]; // [R22]
            conv_start_o <= first_start
                | (conv_tick & rx_active & (state_q != CH_SETTLE));
            stim_period_o <= stim_run & stimulus_divider_tick & phase_wrap; // [R25]
        end
    end
    assign drive_ctl_o = drive_q;

    // Write side: pending sources, one entry per cycle.
    logic i_pend_q, q_pend_q, mark_pend_q, spur_pend_q;
    logic [DATA_W-1:0] i_hold_q, q_hold_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
    wire logic accept_i, accept_q;
    wire logic wr_i, wr_q, wr_s, wr_m;
    wire logic full, empty, wr_en, conv_push;
    wire logic [ENTRY_W-1:0] wr_data;

    assign accept_i = inphase_result_i.valid & inphase_channel_on_i
        & rx_active;
    assign accept_q = quadrature_result_i.valid & quadrature_channel_on_i
        & rx_active;
    assign full = (cnt_q == CNT_W'(DEPTH)); // [R1]
    assign empty = (cnt_q == '0);
    assign wr_i = i_pend_q;
    assign wr_q = q_pend_q & ~i_pend_q;
    assign wr_s = spur_pend_q & ~i_pend_q & ~q_pend_q;
    assign wr_m = mark_pend_q & ~i_pend_q & ~q_pend_q & ~spur_pend_q;
    assign wr_en = (wr_i | wr_q | wr_s | wr_m) & ~full;
    assign conv_push = (wr_i | wr_q) & ~full;
    assign wr_data = wr_i ? {TAG_INPHASE, i_hold_q} // [R2] [R3] [R4]
        : wr_q ? {TAG_QUAD, q_hold_q} // [R5]
        : wr_s ? SPURIOUS_WORD // [R9]
        : MARKER_WORD; // [R6]

    // A new arrival wins over the clearing write of the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            i_pend_q <= 1'b0;
            q_pend_q <= 1'b0;
            mark_pend_q <= 1'b0;
            spur_pend_q <= 1'b0;
            i_hold_q <= '0;
            q_hold_q <= '0;
        end else begin
            i_pend_q <= accept_i | (i_pend_q & ~(wr_i & ~full));
            q_pend_q <= accept_q | (q_pend_q & ~(wr_q & ~full));
            mark_pend_q <= marker_request_i
                | (mark_pend_q & ~(wr_m & ~full)); // [R7]
            // Host drops this entry or avoids it by timing. [R9] [R10]
            spur_pend_q <= (conv_push & chan_fall)
                | (spur_pend_q & ~(wr_s & ~full));
            if (accept_i) begin
                i_hold_q <= inphase_result_i.result;
            end
            if (accept_q) begin
                q_hold_q <= quadrature_result_i.result;
            end
        end
    end

    // Read side with a two-entry output buffer.
    logic inflight_q, from_mem_q, rd_ready_q;
    logic v0_q, v1_q;
    logic [ENTRY_W-1:0] slot0_q, slot1_q;
    logic v0_d, v1_d;
    logic [ENTRY_W-1:0] slot0_d, slot1_d;
    logic [ENTRY_W-1:0] mem_rdata;
    wire logic rd_take, mem_rd, pop;
    wire logic [ENTRY_W-1:0] resp;
    wire logic [1:0] occ_next;

    assign rd_take = rd_req_i & rd_ready_q;
    assign mem_rd = rd_take & ~empty;
    assign resp = from_mem_q ? mem_rdata : INVALID_WORD; // [R8]
    assign pop = v0_q & out_ready_i;
    assign occ_next = 2'(v0_q) + 2'(v1_q) + 2'(inflight_q)
        - 2'(pop) + 2'(rd_take);

    sample_mem u_mem (
        .clk_i(clk_i),
        .we_i(wr_en),
        .waddr_i(wr_ptr_q),
        .wdata_i(wr_data),
        .re_i(mem_rd),
        .raddr_i(rd_ptr_q),
        .rdata_o(mem_rdata)
    );

    always_comb begin
        v0_d = pop ? v1_q : v0_q;
        slot0_d = pop ? slot1_q : slot0_q;
        v1_d = pop ? 1'b0 : v1_q;
        slot1_d = slot1_q;
        if (inflight_q && !v0_d) begin
            v0_d = 1'b1;
            slot0_d = resp;
        end else if (inflight_q) begin
            v1_d = 1'b1;
            slot1_d = resp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fifo_full_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(wr_en) - CNT_W'(mem_rd); // [R1]
            wr_ptr_q <= wr_ptr_q + PTR_W'(wr_en);
            rd_ptr_q <= rd_ptr_q + PTR_W'(mem_rd);
            fifo_full_o <= (cnt_q + CNT_W'(wr_en) - CNT_W'(mem_rd))
                == CNT_W'(DEPTH);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            inflight_q <= 1'b0;
            from_mem_q <= 1'b0;
            rd_ready_q <= 1'b0;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            slot0_q <= '0;
            slot1_q <= '0;
        end else begin
            inflight_q <= rd_take;
            from_mem_q <= mem_rd;
            rd_ready_q <= (occ_next < 2'd2);
            v0_q <= v0_d;
            v1_q <= v1_d;
            slot0_q <= slot0_d;
            slot1_q <= slot1_d;
        end
    end

    assign rd_ready_o = rd_ready_q;
    assign out_valid_o = v0_q;
    assign out_data_o = slot0_q;
    assign fifo_count_o = cnt_q;

    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    wire logic room;
    assign room = (cnt_q < CNT_W'(DEPTH - 8));

    sequence s_marker_written;
        wr_en && wr_data == MARKER_WORD;
    endsequence

    sequence s_spurious_written;
        wr_en && wr_data == SPURIOUS_WORD;
    endsequence

    a_depth_bound: assert property (cnt_q <= CNT_W'(DEPTH)) // [R1]
        else $error("queue count above depth");

    a_inphase_tag: assert property ( // [R4]
        (accept_i && !i_pend_q && room)
        |=> (wr_en
        && wr_data == {TAG_INPHASE, $past(inphase_result_i.result)}))
        else $error("in-phase entry wrong");

    a_quad_tag: assert property ( // [R5]
        (accept_q && !accept_i && !i_pend_q && !q_pend_q && room)
        |=> (wr_en
        && wr_data == {TAG_QUAD, $past(quadrature_result_i.result)}))
        else $error("quadrature entry wrong");

    a_marker_insert: assert property ( // [R7]
        (marker_request_i && room) |-> ##[1:4] s_marker_written)
        else $error("marker not inserted");

    a_marker_selfclear: assert property ( // [R7]
        (wr_m && !full && !marker_request_i) |=> !mark_pend_q)
        else $error("marker request did not clear");

    a_empty_invalid: assert property ( // [R8]
        (rd_take && empty) |=> (inflight_q && resp == INVALID_WORD))
        else $error("empty read not invalid");

    a_spurious_entry: assert property ( // [R9]
        (conv_push && chan_fall && room) |=> ##[0:2] s_spurious_written)
        else $error("spurious entry missing");

    a_start_bound: assert property ( // [R13]
        (state_q == CH_SETTLE && settle_done && chan_on) |=> conv_start_o)
        else $error("first conversion late");

    a_standby_drive: assert property ( // [R18]
        (standby && reference_power_on_i) |=> (drive_ctl_o.return_switch
        && drive_ctl_o.dds_run && drive_ctl_o.amp_low_power
        && !drive_ctl_o.bridge_on && !drive_ctl_o.stim_on))
        else $error("standby drive state wrong");

    a_rx_sleep: assert property ( // [R17]
        (state_q == CH_SLEEP && !receive_awake_in_standby_i)
        |=> !drive_ctl_o.receive_on)
        else $error("receiver awake in standby");

    a_mode_current: assert property ( // [R21]
        (stim_run && stimulus_type_select_i == MODE_SINE_CURRENT)
        |=> (drive_ctl_o.sine_current && !drive_ctl_o.sine_voltage))
        else $error("sine current not selected");

endmodule : sample_fifo_ctrl
`default_nettype wire

// File: verification/host_reader.sv
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bench control
    input wire logic take_i,
    input wire logic stall_i,
    // Device read side
    input wire logic rd_ready_i,
    output logic rd_req_o,
    output logic out_ready_o,
    input wire logic out_valid_i,
    input wire logic [imp_fifo_pkg::ENTRY_W-1:0] out_data_i,
    // Received words
    output logic got_o,
    output logic [imp_fifo_pkg::ENTRY_W-1:0] word_o
);
    int pend = 0;

    // A request stays up until the device takes it, so none is ever lost.
    always @(posedge clk_i) begin
        pend = pend + int'(take_i) - int'(rd_req_o && rd_ready_i);
        if (!rstn_i) pend = 0;
        rd_req_o <= rstn_i && (pend > 0);
        out_ready_o <= rstn_i && !stall_i;
        got_o <= out_valid_i && out_ready_o;
        word_o <= out_data_i;
    end
endmodule : host_reader
`default_nettype wire

// File: verification/bioimpedance_sample_fifo_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bioimpedance_sample_fifo_ctrl_tb_top;
    import imp_fifo_pkg::*;
    localparam int SC = 20;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ref_on = 1'b0;
    logic i_on = 1'b0;
    logic q_on = 1'b0;
    logic awake = 1'b0;
    logic mark = 1'b0;
    logic take = 1'b0;
    logic stall = 1'b0;
    stim_mode_t mode = MODE_SINE_CURRENT;
    conv_t ires = '0;
    conv_t qres = '0;
    logic [DIV_W-1:0] cdiv = 13'h2;
    logic [DAC_W-1:0] dac;
    logic rd_req, rd_ready, out_ready, out_valid, full, conv_st, stim_per, got;
    logic [ENTRY_W-1:0] word;
    entry_t odata;
    logic [CNT_W-1:0] count;
    drive_ctl_t drv;
    int mismatches = 0;
    int check_count = 0;

    always #2.5 clk_i = ~clk_i;

    sample_fifo_ctrl #(.START_CYCLES(SC)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .reference_power_on_i(ref_on), .inphase_channel_on_i(i_on),
        .quadrature_channel_on_i(q_on), .stimulus_type_select_i(mode),
        .receive_awake_in_standby_i(awake), .marker_request_i(mark),
        .stimulus_divider_i(13'h3), .stimulus_oversampling_i(11'h4),
        .converter_divider_i(cdiv), .converter_oversampling_i(11'h5),
        .inphase_result_i(ires), .quadrature_result_i(qres),
        .rd_req_i(rd_req), .rd_ready_o(rd_ready), .out_ready_i(out_ready),
        .out_valid_o(out_valid), .out_data_o(odata), .fifo_count_o(count),
        .fifo_full_o(full), .drive_ctl_o(drv), .dac_code_o(dac),
        .conv_start_o(conv_st), .stim_period_o(stim_per)
    );

    host_reader i_host (
        .clk_i(clk_i), .rstn_i(rstn_i), .take_i(take), .stall_i(stall),
        .rd_ready_i(rd_ready), .rd_req_o(rd_req), .out_ready_o(out_ready),
        .out_valid_i(out_valid), .out_data_i(odata), .got_o(got),
        .word_o(word)
    );

    task automatic tick;
        @(posedge clk_i);
    endtask : tick

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic read_word(output logic [23:0] w);
        int n;
        n = 0;
        take <= 1'b1;
        tick;
        take <= 1'b0;
        while (got !== 1'b1 && n < 50) begin
            tick;
            n++;
        end
        if (n >= 50) mismatches++;
        w = word;
        tick;
    endtask : read_word

    task automatic push(input logic q, input logic [19:0] d);
        if (q) qres <= {1'b1, d};
        else ires <= {1'b1, d};
        tick;
        ires <= '0;
        qres <= '0;
        tick;
    endtask : push

    task automatic gap(input bit s, output int n);
        n = 0;
        do begin
            tick;
            n++;
        end while ((s ? stim_per : conv_st) !== 1'b1 && n < 200);
    endtask : gap

    function automatic drive_ctl_t exp_drv(input logic [1:0] m,
                                           input logic aw);
        drive_ctl_t e;
        e = '0;
        e.bias_hold = 1'b1;
        e.dds_run = 1'b1;
        e.stim_on = m != 2'h3;
        e.sine_current = m == 2'h0;
        e.sine_voltage = m == 2'h1;
        e.bridge_on = m == 2'h2;
        e.return_switch = m == 2'h3;
        e.amp_low_power = m == 2'h3;
        e.receive_on = m != 2'h3 || aw;
        return e;
    endfunction : exp_drv

    task automatic t_tags;
        logic [23:0] w;
        ref_on <= 1'b1;
        repeat (6) tick;
        i_on <= 1'b1;
        q_on <= 1'b1;
        repeat (3) tick;
        ires <= {1'b1, 20'hABCDE};
        qres <= {1'b1, 20'h12345};
        tick;
        ires <= '0;
        qres <= '0;
        repeat (6) tick;
        check("count both", count, 2);
        read_word(w);
        check("inphase", w, {TAG_INPHASE, 20'hABCDE});
        read_word(w);
        check("quad", w, {TAG_QUAD, 20'h12345});
    endtask : t_tags

    task automatic t_marker;
        logic [23:0] w;
        mark <= 1'b1;
        tick;
        mark <= 1'b0;
        repeat (8) tick;
        check("marker count", count, 1);
        read_word(w);
        check("marker", w, MARKER_WORD);
        read_word(w);
        check("empty read", w, INVALID_WORD);
    endtask : t_marker

    task automatic t_modes;
        logic [23:0] w;
        drive_ctl_t e;
        for (int k = 0; k < 5; k++) begin
            mode <= stim_mode_t'(k > 3 ? 3 : k);
            awake <= k == 4;
            repeat (4) tick;
            e = exp_drv(k > 3 ? 2'h3 : 2'(k), k == 4);
            check("drive", drv, e);
            check("stim type", drv[4:2], e[4:2]);
            push(1'b0, 20'h00055);
            repeat (4) tick;
            check("standby take", count, k == 3 ? 0 : 1);
            if (k != 3) read_word(w);
        end
        mode <= MODE_SINE_CURRENT;
        awake <= 1'b0;
        repeat (3) tick;
    endtask : t_modes

    task automatic t_timing;
        int n;
        // A long sample period lets the start-up deadline force the first
        // conversion; the short one starts on its own converter tick.
        for (int p = 0; p < 2; p++) begin
            i_on <= 1'b0;
            q_on <= 1'b0;
            cdiv <= (p == 0) ? 13'h10 : 13'h2;
            repeat (4) tick;
            i_on <= 1'b1;
            gap(1'b0, n);
            check("start bound", n, (p == 0) ? SC + 2 : 12);
        end
        gap(1'b0, n);
        check("sample period", n, 10);
        gap(1'b1, n);
        gap(1'b1, n);
        check("stim period", n, 12);
        // On the period pulse the phase index sits at oversampling - 1.
        check("dac phase", dac, 3);
    endtask : t_timing

    task automatic t_fill;
        int k;
        logic [23:0] w;
        k = 0;
        for (int i = 0; i < 256; i++) push(1'b0, 20'(i));
        repeat (4) tick;
        check("full count", count, 256);
        check("full flag", full, 1);
        push(1'b0, 20'h100);
        stall <= 1'b1;
        take <= 1'b1;
        repeat (3) tick;
        take <= 1'b0;
        repeat (8) tick;
        check("buffer refuses", rd_ready, 0);
        check("buffer holds", out_valid, 1);
        take <= 1'b1;
        for (int n = 0; n < 3000 && k < 257; n++) begin
            stall <= (n % 7) == 3;
            tick;
            if (n == 253) take <= 1'b0;
            if (got === 1'b1) begin
                check("fill word", word, {TAG_INPHASE, 20'(k)});
                k++;
            end
        end
        stall <= 1'b0;
        check("drained", k, 257);
        read_word(w);
        check("drained read", w, INVALID_WORD);
    endtask : t_fill

    task automatic t_spurious;
        logic [23:0] w;
        ires <= {1'b1, 20'h0F0F0};
        tick;
        ires <= '0;
        i_on <= 1'b0;
        repeat (6) tick;
        check("spurious count", count, 2);
        read_word(w);
        check("last sample", w, {TAG_INPHASE, 20'h0F0F0});
        // The host throws this word away.
        read_word(w);
        check("spurious", w, SPURIOUS_WORD);
        ref_on <= 1'b0;
        repeat (3) tick;
        check("bias off", drv.bias_hold, 0);
    endtask : t_spurious

    initial begin
        repeat (10) tick;
        rstn_i <= 1'b1;
        repeat (3) tick;
        check("reset count", count, 0);
        check("reset ready", rd_ready, 1);
        t_tags;
        t_marker;
        t_modes;
        t_timing;
        t_fill;
        t_spurious;
        give_verdict;
    end

    // The run needs about 1200 cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict;
    end
endmodule : bioimpedance_sample_fifo_ctrl_tb_top
`default_nettype wire
